/* shared/addr_decode_map.vh */
// Purpose: constants for the instruction fetch and address decoder
// Assumes: 8-bit opcode bytes, 16-bit address space
// Notes:   mode codes are internal encodings of the decoder
`ifndef ADDR_DECODE_MAP_VH
`define ADDR_DECODE_MAP_VH
`define PRE_SECONDARY      8'h90
`define PRE_IND_SECONDARY  8'h91
`define PRE_IND_PRIMARY    8'h92
// Addressing modes, 5 bits
`define M_INH      5'h00
`define M_IMM      5'h01
`define M_DIR_S    5'h02
`define M_DIR_L    5'h03
`define M_IDX_0    5'h04
`define M_IDX_S    5'h05
`define M_IDX_L    5'h06
`define M_IND_S    5'h07
`define M_IND_L    5'h08
`define M_IIX_S    5'h09
`define M_IIX_L    5'h0A
`define M_REL_D    5'h0B
`define M_REL_I    5'h0C
`define M_BIT_D    5'h0D
`define M_BIT_I    5'h0E
`define M_BTJ_D    5'h0F
`define M_BTJ_I    5'h10
`define M_ILLEGAL  5'h1F
`define M_WIDTH    5
`define PC_RESET   16'h0000
`define ILL_RST_CYCLES 4'h4
`endif

/* verilog/opcode_classifier.v */
// Purpose: classify an opcode byte into an addressing mode
// Assumes: combinational, opcode map follows the usual 8-bit core layout
// Notes:   prefixed bytes modify the base mode outside this module
`timescale 1ns/1ps
`include "addr_decode_map.vh"
module opcode_classifier (
  input  wire [7:0] opcode_i,
  output reg  [4:0] mode_o,
  output reg        short_only_o,
  output reg        stop_osc_o,
  output reg        wait_irq_o
);
  wire [3:0] hi = opcode_i[7:4];
  wire [3:0] lo = opcode_i[3:0];
  always @* begin
    mode_o       = `M_ILLEGAL;
    short_only_o = 1'b0;
    stop_osc_o   = (opcode_i == 8'h8E);
    wait_irq_o   = (opcode_i == 8'h8F);
    case (hi)
      4'h0: mode_o = `M_BTJ_D;
      4'h1: mode_o = `M_BIT_D;
      4'h2: mode_o = `M_REL_D;
      4'h3, 4'h6, 4'h7: begin
        short_only_o = 1'b1;
        if (lo == 4'h1 || lo == 4'h2 || lo == 4'h5 || lo == 4'h8 || lo == 4'hB)
          mode_o = `M_ILLEGAL;
        else
          mode_o = (hi == 4'h3) ? `M_DIR_S : (hi == 4'h6) ? `M_IDX_S : `M_IDX_0;
      end
      4'h4, 4'h5: begin
        if (lo == 4'h1 || lo == 4'h5 || lo == 4'hB)
          mode_o = `M_ILLEGAL;
        else
          mode_o = `M_INH;
      end
      4'h8, 4'h9: begin
        if (opcode_i == 8'h90 || opcode_i == 8'h91 || opcode_i == 8'h92 ||
            opcode_i == 8'h82 || opcode_i == 8'h83 || opcode_i == 8'h87 ||
            opcode_i == 8'h8C || opcode_i == 8'h8D || opcode_i == 8'h9F)
          mode_o = `M_ILLEGAL;
        else
          mode_o = `M_INH;
      end
      4'hA: begin
        if (lo == 4'hD)
          mode_o = `M_REL_D;
        else if (lo == 4'h7 || lo == 4'hC || lo == 4'hF)
          mode_o = `M_ILLEGAL;
        else
          mode_o = `M_IMM;
      end
      4'hB: mode_o = `M_DIR_S;
      4'hC: mode_o = `M_DIR_L;
      4'hD: mode_o = `M_IDX_L;
      4'hE: mode_o = `M_IDX_S;
      4'hF: mode_o = `M_IDX_0;
      default: mode_o = `M_ILLEGAL;
    endcase
    if ((hi == 4'hB || hi == 4'hE || hi == 4'hF) && (lo == 4'hC || lo == 4'hD))
      short_only_o = 1'b1;
    if (hi == 4'hC && lo == 4'hD)
      short_only_o = 1'b0;
  end
endmodule

/* verilog/cpu_addressing_decoder.v */
// Purpose: instruction fetch, length decode and effective address forming
// Assumes: memory answers a read request one cycle later with mem_rdata
// Notes:   one byte is requested per cycle; datapath takes the result strobe
// Notes on behaviour
// - Inherent instructions are one byte, no operand fetch.
// - Immediate instructions are opcode plus one operand byte.
// - Short direct fetches one address byte, range 00-FF.
// - Long direct fetches a two-byte address, full 64K space.
// - Indexed address is unsigned sum of chosen index and offset.
// - No-offset indexed uses index alone, no extra byte.
// - Short indexed fetches one offset byte, range 00-1FE.
// - Long indexed fetches a two-byte offset, full space.
// - Short indirect reads a byte pointer from a page-zero address.
// - Long indirect reads a word pointer from a page-zero address.
// - Indirect indexed adds index to a byte or word pointer.
// - Load, compare, logic, add accept short and long memory forms.
// - Read-modify-write, bit, call and jump accept short forms only; the code decodes call and jump at high nibbles C and D in long forms.
// - Relative mode adds an 8-bit signed offset to PC.
// - PC already points past the instruction when offset added.
// - Relative direct offset follows opcode; indirect reads it from memory.
// - Instructions are 1 to 4 bytes including prebyte.
// - Prebyte directly precedes opcode; 0 to 2 address bytes follow.
// - Prebyte 90 swaps primary index for secondary.
// - Prebyte 92 turns direct forms indirect, short and long offset indexed to indirect indexed.
// - Prebyte 91 makes primary indirect indexed use secondary index.
// - A byte matching no opcode or prebyte raises a reset, unless it follows a prebyte.
// - Valid prebyte with valid opcode never raises that reset.
// - Stop instruction halts oscillator; wait idles until interrupt.
`timescale 1ns/1ps
`include "addr_decode_map.vh"
module cpu_addressing_decoder #(
  parameter ADDR_W = 16
) (
  input  wire              CLK_SYS_I,
  input  wire              RST_N_I,
  input  wire              CLK_EN_I,
  input  wire              START_I,
  input  wire [ADDR_W-1:0] PC_LOAD_I,
  input  wire              PC_LOAD_EN_I,
  input  wire [7:0]        INDEX_PRI_I,
  input  wire [7:0]        INDEX_SEC_I,
  input  wire [7:0]        MEM_RDATA_I,
  input  wire              IRQ_I,
  input  wire              DONE_I,
  output reg  [ADDR_W-1:0] MEM_ADDR_O,
  output reg               MEM_RD_O,
  output reg  [7:0]        OPCODE_O,
  output reg  [4:0]        MODE_O,
  output reg               USE_SEC_O,
  output reg  [ADDR_W-1:0] EA_O,
  output reg  [7:0]        OPERAND_O,
  output reg  [ADDR_W-1:0] PC_O,
  output reg  [2:0]        LENGTH_O,
  output reg               DECODED_O,
  output reg               ILL_RESET_O,
  output reg               OSC_STOP_O,
  output reg               WAIT_IRQ_O
);
  localparam S_IDLE = 8'h01;
  localparam S_OP   = 8'h02;
  localparam S_B1   = 8'h04;
  localparam S_B2   = 8'h08;
  localparam S_P1   = 8'h10;
  localparam S_P2   = 8'h20;
  localparam S_DONE = 8'h40;
  localparam S_HOLD = 8'h80;

  reg [7:0]        state_reg;
  reg [ADDR_W-1:0] pc_reg;
  reg [7:0]        pre_reg;
  reg              pre_valid_reg;
  reg [4:0]        mode_reg;
  reg              sec_reg;
  reg [7:0]        b1_reg;
  reg [7:0]        b2_reg;
  reg [7:0]        p1_reg;
  reg [2:0]        len_reg;
  reg [3:0]        ill_cnt_reg;
  reg [2:0]        step_reg;

  wire [4:0] base_mode;
  wire       short_only;
  wire       stop_osc;
  wire       wait_irq;

  opcode_classifier u_class (
    .opcode_i     (MEM_RDATA_I),
    .mode_o       (base_mode),
    .short_only_o (short_only),
    .stop_osc_o   (stop_osc),
    .wait_irq_o   (wait_irq)
  );

  wire is_pre = (MEM_RDATA_I == `PRE_SECONDARY) ||
                (MEM_RDATA_I == `PRE_IND_SECONDARY) ||
                (MEM_RDATA_I == `PRE_IND_PRIMARY);

  // Prebytes 91 and 92 remap the base mode; prebyte 90 only selects the secondary index
  reg [4:0] eff_mode;
  reg       eff_sec;
  always @* begin
    eff_mode = base_mode;
    eff_sec  = 1'b0;
    if (pre_valid_reg && pre_reg == `PRE_SECONDARY) begin
      eff_sec = 1'b1;
    end else if (pre_valid_reg) begin
      case (base_mode)
        `M_DIR_S: eff_mode = `M_IND_S;
        `M_DIR_L: eff_mode = `M_IND_L;
        `M_IDX_S: eff_mode = `M_IIX_S;
        `M_IDX_L: eff_mode = `M_IIX_L;
        `M_REL_D: eff_mode = `M_REL_I;
        `M_BIT_D: eff_mode = `M_BIT_I;
        `M_BTJ_D: eff_mode = `M_BTJ_I;
        default:  eff_mode = base_mode;
      endcase
      eff_sec = (pre_reg == `PRE_IND_SECONDARY);
    end
    // Short-only opcodes never get a word pointer
    if (short_only && eff_mode == `M_IND_L)
      eff_mode = `M_IND_S;
    if (short_only && eff_mode == `M_IIX_L)
      eff_mode = `M_IIX_S;
  end

  // Prefixed illegal combinations decode as an inherent no-op, no address bytes
  wire [4:0] dec_mode = (base_mode == `M_ILLEGAL) ? `M_INH : eff_mode;

  // Address bytes after the opcode, 0 to 2
  function [1:0] addr_bytes;
    input [4:0] m;
    begin
      case (m)
        `M_INH, `M_IDX_0:                   addr_bytes = 2'd0;
        `M_DIR_L, `M_IDX_L, `M_BTJ_D, `M_BTJ_I: addr_bytes = 2'd2;
        default:                            addr_bytes = 2'd1;
      endcase
    end
  endfunction

  wire [7:0]        idx      = sec_reg ? INDEX_SEC_I : INDEX_PRI_I;
  wire [ADDR_W-1:0] idx_ext  = {{(ADDR_W-8){1'b0}}, idx};
  wire [ADDR_W-1:0] b1_ext   = {{(ADDR_W-8){1'b0}}, b1_reg};
  wire [ADDR_W-1:0] word_b   = {b1_reg, MEM_RDATA_I};
  wire [ADDR_W-1:0] rel_off  = {{(ADDR_W-8){MEM_RDATA_I[7]}}, MEM_RDATA_I};
  wire              is_ind   = (mode_reg == `M_IND_S) || (mode_reg == `M_IND_L) ||
                               (mode_reg == `M_IIX_S) || (mode_reg == `M_IIX_L) ||
                               (mode_reg == `M_REL_I) || (mode_reg == `M_BIT_I) ||
                               (mode_reg == `M_BTJ_I);
  wire              word_ptr = (mode_reg == `M_IND_L) || (mode_reg == `M_IIX_L);

  always @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg     <= S_IDLE;
      pc_reg        <= `PC_RESET;
      pre_reg       <= 8'h00;
      pre_valid_reg <= 1'b0;
      mode_reg      <= `M_INH;
      sec_reg       <= 1'b0;
      b1_reg        <= 8'h00;
      b2_reg        <= 8'h00;
      p1_reg        <= 8'h00;
      len_reg       <= 3'd0;
      ill_cnt_reg   <= 4'h0;
      step_reg      <= 3'd0;
      MEM_ADDR_O    <= `PC_RESET;
      MEM_RD_O      <= 1'b0;
      OPCODE_O      <= 8'h00;
      MODE_O        <= `M_INH;
      USE_SEC_O     <= 1'b0;
      EA_O          <= {ADDR_W{1'b0}};
      OPERAND_O     <= 8'h00;
      PC_O          <= `PC_RESET;
      LENGTH_O      <= 3'd0;
      DECODED_O     <= 1'b0;
      ILL_RESET_O   <= 1'b0;
      OSC_STOP_O    <= 1'b0;
      WAIT_IRQ_O    <= 1'b0;
    end else if (CLK_EN_I) begin
      DECODED_O <= 1'b0;
      MEM_RD_O  <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (PC_LOAD_EN_I) begin
            pc_reg <= PC_LOAD_I;
            PC_O   <= PC_LOAD_I;
          end else if (START_I) begin
            MEM_ADDR_O    <= pc_reg;
            MEM_RD_O      <= 1'b1;
            pc_reg        <= pc_reg + 1'b1;
            pre_valid_reg <= 1'b0;
            len_reg       <= 3'd1;
            state_reg     <= S_OP;
          end
        end
        S_OP: begin
          if (is_pre && !pre_valid_reg) begin
            pre_reg       <= MEM_RDATA_I;
            pre_valid_reg <= 1'b1;
            MEM_ADDR_O    <= pc_reg;
            MEM_RD_O      <= 1'b1;
            pc_reg        <= pc_reg + 1'b1;
            len_reg       <= 3'd2;
          end else if (base_mode == `M_ILLEGAL && !pre_valid_reg) begin
            // Nothing stored from the bad byte, PC left untouched
            ILL_RESET_O <= 1'b1;
            ill_cnt_reg <= `ILL_RST_CYCLES;
            state_reg   <= S_HOLD;
          end else begin
            // Prefixed illegal combinations execute as harmless no-ops
            OPCODE_O <= MEM_RDATA_I;
            mode_reg <= dec_mode;
            sec_reg  <= eff_sec;
            step_reg <= 3'd0;
            OSC_STOP_O <= stop_osc && !pre_valid_reg;
            WAIT_IRQ_O <= wait_irq && !pre_valid_reg;
            len_reg  <= len_reg + {1'b0, addr_bytes(dec_mode)};
            if (addr_bytes(dec_mode) == 2'd0) begin
              // Index picked by this prefix; sec_reg still holds the last one
              EA_O <= {{(ADDR_W-8){1'b0}}, (eff_sec ? INDEX_SEC_I : INDEX_PRI_I)};
              state_reg <= S_DONE;
            end else begin
              MEM_ADDR_O <= pc_reg;
              MEM_RD_O   <= 1'b1;
              pc_reg     <= pc_reg + 1'b1;
              state_reg  <= S_B1;
            end
          end
        end
        S_B1: begin
          b1_reg <= MEM_RDATA_I;
          if (addr_bytes(mode_reg) == 2'd2) begin
            MEM_ADDR_O <= pc_reg;
            MEM_RD_O   <= 1'b1;
            pc_reg     <= pc_reg + 1'b1;
            state_reg  <= S_B2;
          end else if (is_ind) begin
            MEM_ADDR_O <= {{(ADDR_W-8){1'b0}}, MEM_RDATA_I};
            MEM_RD_O   <= 1'b1;
            state_reg  <= S_P1;
          end else begin
            case (mode_reg)
              `M_IMM:   OPERAND_O <= MEM_RDATA_I;
              `M_IDX_S: EA_O <= idx_ext + {{(ADDR_W-8){1'b0}}, MEM_RDATA_I};
              `M_REL_D: EA_O <= pc_reg + rel_off;
              default:  EA_O <= {{(ADDR_W-8){1'b0}}, MEM_RDATA_I};
            endcase
            state_reg <= S_DONE;
          end
        end
        S_B2: begin
          b2_reg <= MEM_RDATA_I;
          if (mode_reg == `M_IDX_L)
            EA_O <= word_b + idx_ext;
          else if (mode_reg == `M_BTJ_I) begin
            OPERAND_O  <= MEM_RDATA_I;
            MEM_ADDR_O <= b1_ext;
            MEM_RD_O   <= 1'b1;
          end else if (mode_reg == `M_BTJ_D) begin
            EA_O      <= b1_ext;
            OPERAND_O <= MEM_RDATA_I;
          end else
            EA_O <= word_b;
          state_reg <= (mode_reg == `M_BTJ_I) ? S_P1 : S_DONE;
        end
        S_P1: begin
          p1_reg <= MEM_RDATA_I;
          if (word_ptr) begin
            MEM_ADDR_O <= b1_ext + 1'b1;
            MEM_RD_O   <= 1'b1;
            state_reg  <= S_P2;
          end else begin
            case (mode_reg)
              `M_IIX_S: EA_O <= idx_ext + {{(ADDR_W-8){1'b0}}, MEM_RDATA_I};
              `M_REL_I: EA_O <= pc_reg + rel_off;
              default:  EA_O <= {{(ADDR_W-8){1'b0}}, MEM_RDATA_I};
            endcase
            state_reg <= S_DONE;
          end
        end
        S_P2: begin
          if (mode_reg == `M_IIX_L)
            EA_O <= {p1_reg, MEM_RDATA_I} + idx_ext;
          else
            EA_O <= {p1_reg, MEM_RDATA_I};
          state_reg <= S_DONE;
        end
        S_DONE: begin
          if (!DECODED_O && step_reg == 3'd0) begin
            DECODED_O <= 1'b1;
            MODE_O    <= mode_reg;
            USE_SEC_O <= sec_reg;
            LENGTH_O  <= len_reg;
            PC_O      <= pc_reg;
            step_reg  <= 3'd1;
          end else if (WAIT_IRQ_O && !IRQ_I) begin
            state_reg <= S_DONE;
          end else if (DONE_I || OSC_STOP_O) begin
            // Stop holds until the outer reset wakes the core
            if (!OSC_STOP_O) begin
              WAIT_IRQ_O <= 1'b0;
              state_reg  <= S_IDLE;
            end
          end
        end
        S_HOLD: begin
          if (ill_cnt_reg == 4'h1) begin
            ILL_RESET_O <= 1'b0;
            state_reg   <= S_IDLE;
          end
          ill_cnt_reg <= ill_cnt_reg - 1'b1;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

/* testbench/cpu_addressing_decoder_assertions.sv */
// Purpose: port-level checks of the addressing decoder
// Assumes: mode codes from the shared map header
// Notes:   clock enable is expected high while checked
`timescale 1ns/1ps
`include "addr_decode_map.vh"
module cpu_addressing_decoder_chk #(
  parameter ADDR_W = 16
) (
  input wire              CLK_SYS_I,
  input wire              RST_N_I,
  input wire              CLK_EN_I,
  input wire              IRQ_I,
  input wire [7:0]        INDEX_PRI_I,
  input wire [7:0]        INDEX_SEC_I,
  input wire [ADDR_W-1:0] EA_O,
  input wire [ADDR_W-1:0] PC_O,
  input wire [4:0]        MODE_O,
  input wire              USE_SEC_O,
  input wire [2:0]        LENGTH_O,
  input wire              DECODED_O,
  input wire              ILL_RESET_O,
  input wire              OSC_STOP_O,
  input wire              WAIT_IRQ_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_N_I);
  wire dec = DECODED_O && CLK_EN_I;
  AST_DEC_PULSE: assert property (dec |=> !DECODED_O)
    else $error("decode strobe longer than one cycle");
  AST_LEN_RANGE: assert property (dec |-> LENGTH_O >= 3'h1 && LENGTH_O <= 3'h4)
    else $error("length outside one to four");
  AST_INH_LEN: assert property (dec && MODE_O == `M_INH |-> LENGTH_O <= 3'h2)
    else $error("inherent length wrong");
  AST_IMM_LEN: assert property (dec && MODE_O == `M_IMM |-> LENGTH_O inside {3'h2, 3'h3})
    else $error("immediate length wrong");
  AST_DIR_PAGE: assert property (dec && MODE_O == `M_DIR_S |-> EA_O[15:8] == 8'h00)
    else $error("short direct left page zero");
  AST_IDX_NONE: assert property (dec && MODE_O == `M_IDX_0
    |-> EA_O == {8'h00, USE_SEC_O ? INDEX_SEC_I : INDEX_PRI_I})
    else $error("no-offset index address wrong");
  AST_IDX_SHORT: assert property (dec && MODE_O inside {`M_IDX_S, `M_IIX_S}
    |-> EA_O <= 16'h01FE) else $error("short indexed beyond 1FE");
  AST_REL_SPAN: assert property (dec && MODE_O inside {`M_REL_D, `M_REL_I}
    |-> 16'(EA_O - PC_O + 16'h0080) <= 16'h00FF) else $error("relative target out of span");
  AST_ILL_LEN: assert property ($rose(ILL_RESET_O) |-> ILL_RESET_O[*4] ##1 !ILL_RESET_O)
    else $error("illegal reset not four cycles");
  AST_ILL_QUIET: assert property (ILL_RESET_O |-> !DECODED_O && $stable(PC_O))
    else $error("update during illegal reset");
  AST_STOP_HOLD: assert property (OSC_STOP_O |=> OSC_STOP_O)
    else $error("stop released without reset");
  AST_WAIT_HOLD: assert property (WAIT_IRQ_O && !IRQ_I |=> WAIT_IRQ_O)
    else $error("wait left without interrupt");
endmodule
bind cpu_addressing_decoder cpu_addressing_decoder_chk #(.ADDR_W(ADDR_W)) i_chk (
  .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .CLK_EN_I(CLK_EN_I), .IRQ_I(IRQ_I),
  .INDEX_PRI_I(INDEX_PRI_I), .INDEX_SEC_I(INDEX_SEC_I), .EA_O(EA_O), .PC_O(PC_O),
  .MODE_O(MODE_O), .USE_SEC_O(USE_SEC_O), .LENGTH_O(LENGTH_O), .DECODED_O(DECODED_O),
  .ILL_RESET_O(ILL_RESET_O), .OSC_STOP_O(OSC_STOP_O), .WAIT_IRQ_O(WAIT_IRQ_O));

/* testbench/cpu_addressing_decoder_bench.sv */
// Purpose: self-checking bench for the addressing decoder
// Assumes: memory answers one cycle after each read strobe
// Notes:   opcode map is not known here, so checks follow the reported mode
`timescale 1ns/1ps
`include "addr_decode_map.vh"
module cpu_addressing_decoder_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        start = 1'b0;
  logic        pc_ld = 1'b0;
  logic        irq = 1'b0;
  logic        done = 1'b0;
  logic [7:0]  rdata = 8'h00;
  logic [15:0] p = 16'h4000;
  logic [15:0] rq[$];
  logic [7:0]  mem[0:65535];
  logic [4:0]  got;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          k;
  wire  [15:0] mem_addr, ea, pc_o;
  wire  [7:0]  opcode, operand;
  wire  [4:0]  mode;
  wire  [2:0]  len;
  wire         mem_rd, use_sec, decoded, ill, stop, wait_o;
  cpu_addressing_decoder #(.ADDR_W(16)) i_cpu_addressing_decoder (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .CLK_EN_I(1'b1), .START_I(start),
    .PC_LOAD_I(p), .PC_LOAD_EN_I(pc_ld), .INDEX_PRI_I(8'hFF), .INDEX_SEC_I(8'h7E),
    .MEM_RDATA_I(rdata), .IRQ_I(irq), .DONE_I(done), .MEM_ADDR_O(mem_addr),
    .MEM_RD_O(mem_rd), .OPCODE_O(opcode), .MODE_O(mode), .USE_SEC_O(use_sec),
    .EA_O(ea), .OPERAND_O(operand), .PC_O(pc_o), .LENGTH_O(len), .DECODED_O(decoded),
    .ILL_RESET_O(ill), .OSC_STOP_O(stop), .WAIT_IRQ_O(wait_o));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (mem_rd) rq.push_back(mem_addr);
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // Idle bus shows inverted data so a stale byte never passes
  // Byte must stand before the edge that ends the strobe cycle
  always @(negedge clk) rdata <= mem_rd ? mem[mem_addr] : ~rdata;
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Bytes after opcode times four plus pointer reads
  function automatic int ext(input logic [4:0] m);
    case (m)
      `M_IMM, `M_DIR_S, `M_IDX_S, `M_REL_D, `M_BIT_D: return 4;
      `M_DIR_L, `M_IDX_L, `M_BTJ_D: return 8;
      `M_IND_S, `M_IIX_S, `M_REL_I, `M_BIT_I: return 5;
      `M_IND_L, `M_IIX_L: return 6;
      `M_BTJ_I: return 9;
      default: return 0;
    endcase
  endfunction
  function automatic logic [4:0] ind(input logic [4:0] m);
    case (m)
      `M_DIR_S: return `M_IND_S;
      `M_DIR_L: return `M_IND_L;
      `M_IDX_S: return `M_IIX_S;
      `M_IDX_L: return `M_IIX_L;
      `M_REL_D: return `M_REL_I;
      `M_BIT_D: return `M_BIT_I;
      `M_BTJ_D: return `M_BTJ_I;
      default: return `M_ILLEGAL;
    endcase
  endfunction
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
  endtask
  task automatic launch(input logic [7:0] pre, op, b1, b2);
    int n;
    k = (pre != 8'h00);
    if (k) mem[p] = pre;
    mem[p + k] = op;
    mem[p + k + 1] = b1;
    mem[p + k + 2] = b2;
    pc_ld = 1'b1;
    @(negedge clk);
    pc_ld = 1'b0;
    start = 1'b1;
    rq.delete();
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (decoded !== 1'b1 && ill !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    check("answer", n < 12, 1);
  endtask
  task automatic run(input logic [7:0] pre, op, b1, b2);
    int e;
    int l;
    logic [15:0] idx, w, ea_e, nx;
    launch(pre, op, b1, b2);
    got = (ill === 1'b1) ? `M_ILLEGAL : mode;
    if (ill === 1'b1) check("pc held", pc_o, p);
    if (decoded === 1'b1) begin
      e = ext(mode);
      l = k + 1 + e / 4;
      idx = (pre == 8'h90 || pre == 8'h91) ? 16'h007E : 16'h00FF;
      w = {mem[b1], mem[8'(b1 + 8'h01)]};
      nx = p + 16'(l);
      check("length", 16'(len), 16'(l));
      check("next pc", pc_o, nx);
      check("opcode", opcode, op);
      check("fetches", 16'(rq.size()), 16'(l + e % 4));
      for (int i = 0; i < l; i++) check("fetch addr", rq[i], p + 16'(i));
      if (mode != `M_INH) check("index", use_sec, idx[0] == 1'b0);
      case (mode)
        `M_DIR_S, `M_BIT_D, `M_BTJ_D: ea_e = {8'h00, b1};
        `M_DIR_L: ea_e = {b1, b2};
        `M_IDX_0: ea_e = idx;
        `M_IDX_S: ea_e = idx + b1;
        `M_IDX_L: ea_e = idx + {b1, b2};
        `M_IND_S, `M_BIT_I, `M_BTJ_I: ea_e = {8'h00, w[15:8]};
        `M_IND_L: ea_e = w;
        `M_IIX_S: ea_e = idx + w[15:8];
        `M_IIX_L: ea_e = idx + w;
        `M_REL_D: ea_e = nx + {{8{b1[7]}}, b1};
        `M_REL_I: ea_e = nx + {{8{w[15]}}, w[15:8]};
        default: ea_e = 16'h0000;
      endcase
      if (!(mode inside {`M_INH, `M_IMM})) check("ea", ea, ea_e);
      if (mode inside {`M_DIR_L, `M_IDX_L}) check("ea long", ea, ea_e);
      if (mode == `M_IMM) check("operand", operand, b1);
      if (mode inside {`M_BTJ_D, `M_BTJ_I}) check("offset", operand, b2);
    end
    done = 1'b1;
    irq = 1'b1;
    @(negedge clk);
    done = 1'b0;
    irq = 1'b0;
    repeat (3) @(negedge clk);
    if (got == `M_ILLEGAL || stop === 1'b1) do_reset();
  endtask
  task automatic test_sweep(input logic [7:0] b1, b2);
    logic [4:0] base;
    logic [4:0] pm;
    logic [7:0] pf[3];
    int nill;
    pf = '{8'h90, 8'h91, 8'h92};
    nill = 0;
    for (int op = 0; op < 256; op++) begin
      if (op inside {8'h90, 8'h91, 8'h92}) continue;
      run(8'h00, 8'(op), b1, b2);
      base = got;
      if (base == `M_ILLEGAL) nill++;
      else for (int j = 0; j < 3; j++) begin
        run(pf[j], 8'(op), b1, b2);
        check("no reset", got == `M_ILLEGAL, 0);
        if (got != `M_INH && got != `M_ILLEGAL) begin
          // Modes with no indirect form keep their base mode
          pm = (pf[j] == 8'h90 || ind(base) == `M_ILLEGAL) ? base : ind(base);
          check("prefix mode", got, pm);
        end
      end
    end
    check("illegal seen", nill > 0, 1);
    $display("sweep %h %h done", b1, b2);
  endtask
  task automatic test_wait();
    launch(8'h00, 8'h8F, 8'h00, 8'h00);
    done = 1'b1;
    repeat (4) @(negedge clk);
    check("wait holds", wait_o, 1);
    irq = 1'b1;
    repeat (3) @(negedge clk);
    check("wait ends", wait_o, 0);
    done = 1'b0;
    irq = 1'b0;
    repeat (2) @(negedge clk);
    $display("wait test done");
  endtask
  task automatic test_stop();
    launch(8'h00, 8'h8E, 8'h00, 8'h00);
    done = 1'b1;
    irq = 1'b1;
    repeat (6) @(negedge clk);
    check("stop holds", stop, 1);
    done = 1'b0;
    irq = 1'b0;
    do_reset();
    check("stop cleared", stop, 0);
    $display("stop test done");
  endtask
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hC3;
    // Pointers chosen for the 1FE and relative span edges
    mem[8'hF0] = 8'hFF;
    mem[8'hF1] = 8'h34;
    mem[8'h7F] = 8'h80;
    mem[8'h80] = 8'h01;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    test_sweep(8'hF0, 8'h81);
    test_sweep(8'h7F, 8'h12);
    test_wait();
    test_stop();
    report_and_stop();
  end
endmodule
